/* shared/tm3_pkg.sv */
// Constants shared by the timer 3 control and status block.
// Assumes an 8-bit special-function register port on the core clock.
package tm3_pkg;
  // ***********************************************
  // Register addresses
  // ***********************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h91;
  localparam logic [7:0] ADDR_RLD_LO = 8'h92;
  localparam logic [7:0] ADDR_RLD_HI = 8'h93;
  localparam logic [7:0] ADDR_CNT_LO = 8'h94;
  localparam logic [7:0] ADDR_CNT_HI = 8'h95;
  // ***********************************************
  // Reset values and byte limits
  // ***********************************************
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [7:0] BYTE_MAX    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  // ***********************************************
  // Control register fields
  // ***********************************************
  localparam int BIT_HFLAG   = 7;
  localparam int BIT_LFLAG   = 6;
  localparam int BIT_LIRQ    = 5;
  localparam int BIT_CAP     = 4;
  localparam int BIT_SPLIT   = 3;
  localparam int BIT_RUN     = 2;
  localparam int BIT_ALT_MSB = 1;
  localparam int BIT_ALT_LSB = 0;
  // ***********************************************
  // Alternate clock codes and divider terminal counts
  // ***********************************************
  localparam logic [1:0] ALT_SYS_DIV12 = 2'h0;
  localparam logic [1:0] ALT_EXT_DIV8  = 2'h1;
  localparam logic [1:0] ALT_RESERVED  = 2'h2;
  localparam logic [1:0] ALT_SLOW_DIV8 = 2'h3;
  localparam logic [3:0] SYS_DIV_LAST  = 4'hB;
  localparam logic [2:0] OSC_DIV_LAST  = 3'h7;
  localparam int         OSC_CH_EXT    = 0;
  localparam int         OSC_CH_SLOW   = 1;
endpackage

/* src/tm3_tick_gen.sv */
// Tick sources for timer 3: core clock / 12, external oscillator / 8,
// slow oscillator / 8 and the slow oscillator falling edge.
// Assumes oscillator inputs are asynchronous to the core clock.
module tm3_tick_gen (
  input  wire logic i_sys_clk,     // Core clock
  input  wire logic i_resetn,      // Async reset, active low
  input  wire logic i_suspend,     // Suspend: skip agreement filter
  input  wire logic i_ext_osc,     // External oscillator pin
  input  wire logic i_slow_osc,    // Slow oscillator output
  output logic      o_tick_div12,  // Core clock / 12 pulse
  output logic      o_tick_ext8,   // External / 8 pulse
  output logic      o_tick_slow8,  // Slow oscillator / 8 pulse
  output logic      o_slow_fall    // Slow oscillator falling edge
);
  // ***********************************************
  // Core clock divide by twelve
  // ***********************************************
  logic [3:0] div12_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div12_r      <= 4'h0;
      o_tick_div12 <= 1'b0;
    end else begin
      o_tick_div12 <= (div12_r == tm3_pkg::SYS_DIV_LAST);
      div12_r      <= (div12_r == tm3_pkg::SYS_DIV_LAST) ? 4'h0 : div12_r + 4'h1;
    end
  end
  // ***********************************************
  // Oscillator synchronisers and divide by eight
  // ***********************************************
  logic [1:0] osc_in;
  logic [1:0] tick8;
  logic [1:0] fall;
  assign osc_in = {i_slow_osc, i_ext_osc};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_osc
      logic [2:0] sync_r;
      logic       lvl_r;
      logic       lvl_nxt;
      logic [2:0] div_r;
      logic       tick_r;
      logic       fall_r;
      // Outside suspend a level counts once stages two and three agree
      assign lvl_nxt = (i_suspend || sync_r[1] == sync_r[2]) ? sync_r[1] : lvl_r;
      always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          sync_r <= 3'h0;
          lvl_r  <= 1'b0;
          div_r  <= 3'h0;
          tick_r <= 1'b0;
          fall_r <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], osc_in[ch]};
          lvl_r  <= lvl_nxt;
          tick_r <= 1'b0;
          fall_r <= lvl_r & ~lvl_nxt;
          if (lvl_nxt && !lvl_r) begin
            div_r  <= div_r + 3'h1;
            tick_r <= (div_r == tm3_pkg::OSC_DIV_LAST);
          end
        end
      end
      // Each channel drives only its own bit of the shared vectors
      assign tick8[ch] = tick_r;
      assign fall[ch]  = fall_r;
    end
  endgenerate
  assign o_tick_ext8  = tick8[tm3_pkg::OSC_CH_EXT];
  assign o_tick_slow8 = tick8[tm3_pkg::OSC_CH_SLOW];
  assign o_slow_fall  = fall[tm3_pkg::OSC_CH_SLOW];
endmodule

/* src/tm3_timer.sv */
// Timer 3 control/status register with its 16-bit or split 8-bit counter.
// Assumes a single-cycle SFR write strobe and address on the core clock.
// How it works
// - High overflow flag sets when the upper count byte wraps from FF to its reload byte.
// - In 16-bit mode the high flag sets when FFFF wraps to the reload pair.
// - Timer irq enable plus set high flag raises the interrupt request.
// - Hardware never clears either overflow flag; software writes them.
// - Low overflow flag sets on every low byte wrap, any mode.
// - Low irq enable plus timer irq enable requests irq on low overflow.
// - Capture enable: slow osc falling edge copies count to reload, flags.
// - Split bit picks one 16-bit or two 8-bit auto-reload timers.
// - Run bit enables counting; in split mode it gates only the high byte.
// - Alternate clock: 00 core/12, 01 ext/8, 10 none, 11 slow/8.
// - Split mode: alternate clock shared; per-byte pick chooses core clock.
// - External and slow sources pass the agreement filter except in suspend.
// - 16-bit wrap from FFFF loads the 16-bit reload pair.
// - Split mode: each byte reloads from its own reload byte; a high byte wrap also reloads the low byte.
module tm3_timer (
  input  wire logic       i_sys_clk,              // Core clock, 25 MHz
  input  wire logic       i_resetn,               // Async reset, active low
  input  wire logic [7:0] i_sfr_addr,             // SFR address
  input  wire logic       i_sfr_wr,               // SFR write strobe
  input  wire logic [7:0] i_sfr_wdata,            // SFR write data
  output logic      [7:0] o_sfr_rdata,            // SFR read data, one cycle late
  input  wire logic       i_timer_irq_enable,     // Timer 3 interrupt enable
  input  wire logic       i_high_byte_clock_pick, // 1: high byte on core clock in split mode
  input  wire logic       i_low_byte_clock_pick,  // 1: low byte on core clock
  input  wire logic       i_suspend,              // Device in suspend
  input  wire logic       i_ext_osc,              // External oscillator
  input  wire logic       i_slow_osc,             // Slow oscillator
  output logic            o_irq_req               // Interrupt request level
);
  // ***********************************************
  // Register state
  // ***********************************************
  logic       hflag_r;
  logic       lflag_r;
  logic       lirq_en_r;
  logic       cap_en_r;
  logic       split_r;
  logic       run_r;
  logic [1:0] alt_r;
  logic [7:0] cnt_lo_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] rld_lo_r;
  logic [7:0] rld_hi_r;
  logic       wr_ctrl;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic       wr_rld_lo;
  logic       wr_rld_hi;
  assign wr_ctrl   = i_sfr_wr && i_sfr_addr == tm3_pkg::ADDR_CTRL;
  assign wr_cnt_lo = i_sfr_wr && i_sfr_addr == tm3_pkg::ADDR_CNT_LO;
  assign wr_cnt_hi = i_sfr_wr && i_sfr_addr == tm3_pkg::ADDR_CNT_HI;
  assign wr_rld_lo = i_sfr_wr && i_sfr_addr == tm3_pkg::ADDR_RLD_LO;
  assign wr_rld_hi = i_sfr_wr && i_sfr_addr == tm3_pkg::ADDR_RLD_HI;
  // ***********************************************
  // Clock sources
  // ***********************************************
  logic tick_div12;
  logic tick_ext8;
  logic tick_slow8;
  logic slow_fall;
  logic alt_tick;
  tm3_tick_gen u_ticks (
    .i_sys_clk    (i_sys_clk),
    .i_resetn     (i_resetn),
    .i_suspend    (i_suspend),
    .i_ext_osc    (i_ext_osc),
    .i_slow_osc   (i_slow_osc),
    .o_tick_div12 (tick_div12),
    .o_tick_ext8  (tick_ext8),
    .o_tick_slow8 (tick_slow8),
    .o_slow_fall  (slow_fall)
  );
  always_comb begin
    unique case (alt_r)
      tm3_pkg::ALT_SYS_DIV12: alt_tick = tick_div12;
      tm3_pkg::ALT_EXT_DIV8:  alt_tick = tick_ext8;
      tm3_pkg::ALT_SLOW_DIV8: alt_tick = tick_slow8;
      tm3_pkg::ALT_RESERVED:  alt_tick = 1'b0;
    endcase
  end
  // ***********************************************
  // Count structure
  // ***********************************************
  logic tick_lo;
  logic tick_hi;
  logic inc_lo;
  logic inc_hi;
  logic lo_wrap;
  logic hi_wrap;
  logic cap_evt;
  assign tick_lo = i_low_byte_clock_pick | alt_tick;
  assign tick_hi = i_high_byte_clock_pick | alt_tick;
  assign inc_lo  = split_r ? tick_lo : (run_r & tick_lo);
  assign lo_wrap = inc_lo && cnt_lo_r == tm3_pkg::BYTE_MAX;
  assign inc_hi  = split_r ? (run_r & tick_hi) : lo_wrap;
  assign hi_wrap = inc_hi && cnt_hi_r == tm3_pkg::BYTE_MAX;
  assign cap_evt = cap_en_r & slow_fall;
  // Software writes to a count byte win over counting in that cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_lo_r <= tm3_pkg::BYTE_RESET;
    end else if (wr_cnt_lo) begin
      cnt_lo_r <= i_sfr_wdata;
    end else if (split_r && lo_wrap) begin
      cnt_lo_r <= rld_lo_r;
    end else if (hi_wrap) begin
      cnt_lo_r <= rld_lo_r;
    end else if (lo_wrap) begin
      cnt_lo_r <= tm3_pkg::BYTE_ZERO;
    end else if (inc_lo) begin
      cnt_lo_r <= cnt_lo_r + 8'h01;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_hi_r <= tm3_pkg::BYTE_RESET;
    end else if (wr_cnt_hi) begin
      cnt_hi_r <= i_sfr_wdata;
    end else if (hi_wrap) begin
      cnt_hi_r <= rld_hi_r;
    end else if (inc_hi) begin
      cnt_hi_r <= cnt_hi_r + 8'h01;
    end
  end
  // Capture wins over a software write to the reload pair
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rld_lo_r <= tm3_pkg::BYTE_RESET;
      rld_hi_r <= tm3_pkg::BYTE_RESET;
    end else if (cap_evt) begin
      rld_lo_r <= cnt_lo_r;
      rld_hi_r <= cnt_hi_r;
    end else begin
      if (wr_rld_lo) begin
        rld_lo_r <= i_sfr_wdata;
      end
      if (wr_rld_hi) begin
        rld_hi_r <= i_sfr_wdata;
      end
    end
  end
  // ***********************************************
  // Control register and flags
  // ***********************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lirq_en_r <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_LIRQ];
      cap_en_r  <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_CAP];
      split_r   <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_SPLIT];
      run_r     <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_RUN];
      alt_r     <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_ALT_MSB:tm3_pkg::BIT_ALT_LSB];
    end else if (wr_ctrl) begin
      lirq_en_r <= i_sfr_wdata[tm3_pkg::BIT_LIRQ];
      cap_en_r  <= i_sfr_wdata[tm3_pkg::BIT_CAP];
      split_r   <= i_sfr_wdata[tm3_pkg::BIT_SPLIT];
      run_r     <= i_sfr_wdata[tm3_pkg::BIT_RUN];
      alt_r     <= i_sfr_wdata[tm3_pkg::BIT_ALT_MSB:tm3_pkg::BIT_ALT_LSB];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hflag_r <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_HFLAG];
      lflag_r <= tm3_pkg::CTRL_RESET[tm3_pkg::BIT_LFLAG];
    end else begin
      // Only a write can lower a flag; an event in the same cycle wins
      hflag_r <= (wr_ctrl ? i_sfr_wdata[tm3_pkg::BIT_HFLAG] : hflag_r)
                 | hi_wrap | cap_evt;
      lflag_r <= (wr_ctrl ? i_sfr_wdata[tm3_pkg::BIT_LFLAG] : lflag_r)
                 | lo_wrap;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= i_timer_irq_enable & (hflag_r | (lirq_en_r & lflag_r));
    end
  end
  // ***********************************************
  // Read data
  // ***********************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sfr_rdata <= 8'h00;
    end else begin
      unique case (i_sfr_addr)
        tm3_pkg::ADDR_CTRL:   o_sfr_rdata <= {hflag_r, lflag_r, lirq_en_r, cap_en_r,
                                              split_r, run_r, alt_r};
        tm3_pkg::ADDR_RLD_LO: o_sfr_rdata <= rld_lo_r;
        tm3_pkg::ADDR_RLD_HI: o_sfr_rdata <= rld_hi_r;
        tm3_pkg::ADDR_CNT_LO: o_sfr_rdata <= cnt_lo_r;
        tm3_pkg::ADDR_CNT_HI: o_sfr_rdata <= cnt_hi_r;
        default:              o_sfr_rdata <= 8'h00;
      endcase
    end
  end
  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  property p_hflag_wrap;
    hi_wrap |=> hflag_r;
  endproperty
  a_hflag_wrap: assert property (p_hflag_wrap) else $error("high flag missed wrap");
  property p_full_wrap;
    !split_r && inc_lo && {cnt_hi_r, cnt_lo_r} == 16'hFFFF && !i_sfr_wr
      |=> hflag_r && {cnt_hi_r, cnt_lo_r} == $past({rld_hi_r, rld_lo_r});
  endproperty
  a_full_wrap: assert property (p_full_wrap) else $error("16-bit wrap wrong");
  property p_irq_high;
    i_timer_irq_enable && hflag_r |=> o_irq_req;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("no irq on high flag");
  property p_no_hw_clear;
    hflag_r && lflag_r && !wr_ctrl |=> hflag_r && lflag_r;
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared by hw");
  property p_lflag_wrap;
    lo_wrap |=> lflag_r ##1 (lflag_r || $past(wr_ctrl));
  endproperty
  a_lflag_wrap: assert property (p_lflag_wrap) else $error("low flag missed wrap");
  property p_irq_low;
    i_timer_irq_enable && lirq_en_r && lo_wrap |=> ##1 o_irq_req;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("no irq on low wrap");
  property p_capture;
    cap_evt |=> {rld_hi_r, rld_lo_r} == $past({cnt_hi_r, cnt_lo_r}) && hflag_r;
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");
  property p_split_run;
    split_r && !run_r && !wr_cnt_hi |=> $stable(cnt_hi_r);
  endproperty
  a_split_run: assert property (p_split_run) else $error("high byte ran stopped");
  property p_split_reload;
    split_r && lo_wrap && !wr_cnt_lo |=> cnt_lo_r == $past(rld_lo_r);
  endproperty
  a_split_reload: assert property (p_split_reload) else $error("low reload wrong");
  property p_set_wins;
    hi_wrap && wr_ctrl && !i_sfr_wdata[tm3_pkg::BIT_HFLAG] |=> hflag_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
  property p_cv_split_both;
    split_r && lo_wrap && hi_wrap;
  endproperty
  c_cv_split_both: cover property (p_cv_split_both);
  property p_cv_full_wrap;
    !split_r && hi_wrap;
  endproperty
  c_cv_full_wrap: cover property (p_cv_full_wrap);
  property p_cv_capture;
    cap_evt ##1 o_irq_req [*2];
  endproperty
  c_cv_capture: cover property (p_cv_capture);
endmodule

/* tb/tm3_timer_tb.sv */
// Self-checking bench for the timer 3 control and status block.
// Assumes tm3_pkg and tm3_timer are compiled first; drives every port itself.
module tm3_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************
  // Stimulus signals and counters
  // ***********************************************
  logic        i_sys_clk              = 1'b0;
  logic        i_resetn               = 1'b0;
  logic [7:0]  i_sfr_addr             = 8'h00;
  logic        i_sfr_wr               = 1'b0;
  logic [7:0]  i_sfr_wdata            = 8'h00;
  logic        i_timer_irq_enable     = 1'b1;
  logic        i_high_byte_clock_pick = 1'b0;
  logic        i_low_byte_clock_pick  = 1'b0;
  logic        i_suspend              = 1'b0;
  logic        i_ext_osc              = 1'b0;
  logic        i_slow_osc             = 1'b0;
  logic [7:0]  o_sfr_rdata;
  logic        o_irq_req;
  logic [31:0] cyc_cnt                = 32'h0000_0000;
  int          failures               = 0;
  int          total_checks           = 0;
  logic [7:0]  v;
  logic [7:0]  rl;

  tm3_timer dut (
    .i_sys_clk              (i_sys_clk),
    .i_resetn               (i_resetn),
    .i_sfr_addr             (i_sfr_addr),
    .i_sfr_wr               (i_sfr_wr),
    .i_sfr_wdata            (i_sfr_wdata),
    .o_sfr_rdata            (o_sfr_rdata),
    .i_timer_irq_enable     (i_timer_irq_enable),
    .i_high_byte_clock_pick (i_high_byte_clock_pick),
    .i_low_byte_clock_pick  (i_low_byte_clock_pick),
    .i_suspend              (i_suspend),
    .i_ext_osc              (i_ext_osc),
    .i_slow_osc             (i_slow_osc),
    .o_irq_req              (o_irq_req)
  );

  always #20 i_sys_clk = ~i_sys_clk;

  // External oscillator period 8 cycles, slow oscillator 32; cut off hangs
  always @(posedge i_sys_clk) begin
    cyc_cnt <= cyc_cnt + 32'd1;
    i_ext_osc <= cyc_cnt[2];
    i_slow_osc <= cyc_cnt[4];
    if (cyc_cnt == 32'd30000) begin
      failures++;
      complete_run();
    end
  end

  // ***********************************************
  // Bus tasks, checks and expectations
  // ***********************************************
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_wr <= 1'b1;
    i_sfr_wdata <= d;
    @(posedge i_sys_clk);
    i_sfr_wr <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [7:0] lo, input logic [7:0] hi,
                     input logic [7:0] got);
    total_checks++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
      failures++;
      $display("Error %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask

  // Read data is valid after the first edge following the address
  task automatic rchk(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    waitc(2);
    @(negedge i_sys_clk);
    chk($sformatf("register_%h", a), lo, hi, o_sfr_rdata);
  endtask

  task automatic ichk(input logic e);
    @(negedge i_sys_clk);
    chk("irq_req", {7'h00, e}, {7'h00, e}, {7'h00, o_irq_req});
  endtask

  function automatic int exp_ticks(input logic [1:0] alt, input int cyc);
    case (alt)
      tm3_pkg::ALT_SYS_DIV12: return cyc / 12;
      tm3_pkg::ALT_EXT_DIV8:  return cyc / 64;
      tm3_pkg::ALT_RESERVED:  return 0;
      default:                return cyc / 256;
    endcase
  endfunction

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    int e;
    logic [1:0] al;
    void'($urandom(32'hf6ceb3ff));
    waitc(2);
    i_resetn <= 1'b1;
    for (int a = 8'h91; a <= 8'h95; a++) rchk(a[7:0], 8'h00, 8'h00);
    v = 8'($urandom) & 8'h2B;
    wr(tm3_pkg::ADDR_CTRL, v);
    rchk(tm3_pkg::ADDR_CTRL, v, v);
    wr(tm3_pkg::ADDR_CTRL, 8'h00);
    wr(8'h96, 8'($urandom));
    rchk(8'h96, 8'h00, 8'h00);
    for (int a = 8'h92; a <= 8'h95; a++) begin
      v = 8'($urandom);
      wr(a[7:0], v);
      rchk(a[7:0], v, v);
    end
    // Full 16-bit wrap from FFFC, reserved alternate source keeps it still
    v = 8'($urandom);
    wr(tm3_pkg::ADDR_RLD_LO, 8'h00);
    wr(tm3_pkg::ADDR_RLD_HI, v);
    wr(tm3_pkg::ADDR_CNT_LO, 8'hFC);
    wr(tm3_pkg::ADDR_CNT_HI, 8'hFF);
    wr(tm3_pkg::ADDR_CTRL, 8'h06);
    i_low_byte_clock_pick <= 1'b1;
    waitc(20);
    i_low_byte_clock_pick <= 1'b0;
    waitc(200);
    rchk(tm3_pkg::ADDR_CTRL, 8'hC6, 8'hC6);
    rchk(tm3_pkg::ADDR_CNT_HI, v, v);
    rchk(tm3_pkg::ADDR_CNT_LO, 8'h0A, 8'h18);
    ichk(1'b1);
    wr(tm3_pkg::ADDR_CTRL, 8'h06);
    waitc(3);
    ichk(1'b0);
    // Wrap of FFFF lands on the same edge as a write that clears both flags
    wr(tm3_pkg::ADDR_CNT_LO, 8'hFE);
    wr(tm3_pkg::ADDR_CNT_HI, 8'hFF);
    i_low_byte_clock_pick <= 1'b1;
    wr(tm3_pkg::ADDR_CTRL, 8'h06);
    i_low_byte_clock_pick <= 1'b0;
    rchk(tm3_pkg::ADDR_CTRL, 8'hC6, 8'hC6);
    // Low byte wrap only, every enable combination
    for (int k = 0; k < 4; k++) begin
      wr(tm3_pkg::ADDR_CNT_HI, 8'h00);
      i_timer_irq_enable <= k[0];
      wr(tm3_pkg::ADDR_CNT_LO, 8'hF0 | 8'($urandom % 8));
      wr(tm3_pkg::ADDR_CTRL, 8'h06 | {2'b00, k[1], 5'h00});
      i_low_byte_clock_pick <= 1'b1;
      waitc(30);
      i_low_byte_clock_pick <= 1'b0;
      waitc(3);
      v = 8'h46 | {2'b00, k[1], 5'h00};
      rchk(tm3_pkg::ADDR_CTRL, v, v);
      ichk(k[0] & k[1]);
      rchk(tm3_pkg::ADDR_CNT_HI, 8'h01, 8'h01);
    end
    // Split mode: low byte runs without the run bit, high byte waits for it
    rl = 8'($urandom) & 8'h7F;
    wr(tm3_pkg::ADDR_CTRL, 8'h08);
    i_timer_irq_enable <= 1'b1;
    wr(tm3_pkg::ADDR_RLD_LO, rl);
    wr(tm3_pkg::ADDR_CNT_HI, 8'h10);
    wr(tm3_pkg::ADDR_CNT_LO, 8'hF0);
    i_low_byte_clock_pick <= 1'b1;
    i_high_byte_clock_pick <= 1'b1;
    waitc(30);
    rchk(tm3_pkg::ADDR_CTRL, 8'h48, 8'h48);
    rchk(tm3_pkg::ADDR_CNT_HI, 8'h10, 8'h10);
    rchk(tm3_pkg::ADDR_CNT_LO, rl, rl + 8'd40);
    v = 8'($urandom) & 8'h7F;
    wr(tm3_pkg::ADDR_RLD_HI, v);
    wr(tm3_pkg::ADDR_CNT_HI, 8'hFC);
    wr(tm3_pkg::ADDR_CTRL, 8'h0C);
    waitc(20);
    rchk(tm3_pkg::ADDR_CTRL, 8'h8C, 8'h8C);
    wr(tm3_pkg::ADDR_CTRL, 8'h08);
    i_high_byte_clock_pick <= 1'b0;
    i_low_byte_clock_pick <= 1'b0;
    rchk(tm3_pkg::ADDR_CNT_HI, v, v + 8'd25);
    // Every alternate source code, then external source in suspend
    for (int k = 0; k < 5; k++) begin
      al = (k == 4) ? tm3_pkg::ALT_EXT_DIV8 : k[1:0];
      e = exp_ticks(al, 1536);
      wr(tm3_pkg::ADDR_CNT_LO, 8'h00);
      i_suspend <= (k == 4);
      wr(tm3_pkg::ADDR_CNT_HI, 8'h00);
      wr(tm3_pkg::ADDR_CTRL, 8'h04 | {6'h00, al});
      waitc(1535);
      wr(tm3_pkg::ADDR_CTRL, {6'h00, al});
      rchk(tm3_pkg::ADDR_CNT_LO, 8'((e > 2) ? e - 2 : 0), 8'(e + 2));
      rchk(tm3_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
    end
    // Capture of the count on slow oscillator falling edges
    wr(tm3_pkg::ADDR_RLD_LO, 8'h00);
    i_suspend <= 1'b0;
    wr(tm3_pkg::ADDR_RLD_HI, 8'h00);
    wr(tm3_pkg::ADDR_CNT_LO, 8'h00);
    wr(tm3_pkg::ADDR_CNT_HI, 8'h10);
    wr(tm3_pkg::ADDR_CTRL, 8'h14);
    i_low_byte_clock_pick <= 1'b1;
    waitc(50);
    ichk(1'b1);
    rchk(tm3_pkg::ADDR_CTRL, 8'h94, 8'h94);
    wr(tm3_pkg::ADDR_CTRL, 8'h00);
    i_low_byte_clock_pick <= 1'b0;
    rchk(tm3_pkg::ADDR_RLD_HI, 8'h10, 8'h10);
    rchk(tm3_pkg::ADDR_RLD_LO, 8'h01, 8'h40);
    complete_run();
  end
endmodule
